// File: core/imr_core.sv
// Memory mapper with internal RAM, system stack and working-register bank logic
//
// Operation
// - Segmentation off confines external accesses to segment 0
// - Instruction fetches always use even byte addresses
// - Segment change only by inter-segment jump or call; here an APB write to A_CSEG also changes it
// - External operands reachable only by long addressing
// - Transfer pointers reach segment 0 ignoring page pointers
// - No single-bit addressing of external memory
// - Traps and interrupts branch to fixed vector address
// - 1 Kbyte internal RAM always enabled
// - Long internal RAM access needs page pointer 3
// - Implicit RAM accesses ignore page pointers
// - Short register fields decoded relative to context pointer
// - Bit access on upper RAM and active bank
// - Stack size field selects area below fixed top
// - Stack uses stack pointer and grows downward
// - Stack accepts word accesses only
// - Bound registers flag stack leaving its area
// - Context pointer bank lies within internal RAM
// - Sixteen byte registers overlay first eight words
// - Bank grows upward, at most 32 bytes
// - Switch context loads pointer and saves old one
// - Top 32 RAM bytes hold transfer pointers
//
// Register access over APB and the address map are this design's own decisions.
`default_nettype none
module imr_core (
  input  wire logic               pclk,     // APB clock, 20 MHz
  input  wire logic               presetn,  // Async reset, active low
  input  wire logic               psel,     // APB select
  input  wire logic               penable,  // APB enable
  input  wire logic               pwrite,   // APB direction
  input  wire logic [7:0]         paddr,    // APB byte address
  input  wire logic [31:0]        pwdata,   // APB write data
  output logic      [31:0]        prdata,   // APB read data
  output logic                    pready,   // APB ready
  output logic                    pslverr,  // APB error, unmapped offset
  input  wire imr_pkg::imr_req_t  req_i,    // CPU core access request
  output imr_pkg::imr_rsp_t       rsp_o,    // Mapped answer, one cycle later
  output logic      [15:0]        rdata_o   // Internal RAM word read data
);

  typedef struct packed {
    logic              seg_dis;
    logic [1:0]        stk_size;
    logic [15:0]       cp;
    logic [15:0]       sp;
    logic [15:0]       ovb;
    logic [15:0]       unb;
    logic [1:0]        code_segment_pointer;
    logic [3:0][9:0]   data_page_pointer;
    logic              acc_err;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    imr_pkg::imr_rsp_t rsp;
  } imr_state_t;

  imr_state_t  st_r;
  imr_state_t  st_nxt;
  logic [15:0] mem [512];
  logic [15:0] rd_r;

  logic        ram_we;
  logic        ram_act;
  logic [8:0]  ram_idx;
  logic [15:0] ram_mask;
  logic [15:0] ram_wd;
  logic [15:0] stk_bot;
  logic        ovf;
  logic        unf;
  logic        out_area;
  logic        mapped;
  logic [31:0] rd_val;
  logic [15:0] a16;
  logic [15:0] gpr_a;
  logic [3:0]  gpr_n;
  logic [9:0]  page;
  logic [1:0]  di;

  function automatic imr_pkg::imr_region_t region_of(input logic [17:0] a);
    if (a[17:16] != 2'h0 || a[15:0] < imr_pkg::RAM_BASE) begin
      return imr_pkg::R_EXT;
    end else if (a[15:0] <= imr_pkg::RAM_LAST) begin
      return imr_pkg::R_RAM;
    end else begin
      return imr_pkg::R_SFR;
    end
  endfunction

  function automatic logic in_bank(input logic [15:0] a, input logic [15:0] cp);
    return (a >= cp) && (a < 16'(cp + imr_pkg::BANK_BYTES));
  endfunction

  function automatic logic cp_ok(input logic [15:0] v);
    return (v >= imr_pkg::RAM_BASE) && (v <= imr_pkg::CP_MAX) && !v[0];
  endfunction

  // --------------------------------------------------------------------
  // Stack area and bound checks
  // --------------------------------------------------------------------
  always_comb begin
    stk_bot  = 16'(imr_pkg::STK_TOP_EXCL - (imr_pkg::STK_BYTES >> st_r.stk_size));
    ovf      = st_r.sp < st_r.ovb;
    unf      = st_r.sp > st_r.unb;
    out_area = (st_r.sp < stk_bot) || (st_r.sp > imr_pkg::STK_TOP_EXCL);
  end

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    di     = 2'(paddr[5:2] - imr_pkg::DPP0_IDX);
    if (paddr == imr_pkg::A_SYSCFG) begin
      rd_val[imr_pkg::CFG_SEGDIS_BIT]                       = st_r.seg_dis;
      rd_val[imr_pkg::CFG_STACK_SIZE_FIELD_LSB +: 2]                   = st_r.stk_size;
    end else if (paddr == imr_pkg::A_CTXPTR) begin
      rd_val[15:0] = st_r.cp;
    end else if (paddr == imr_pkg::A_STKPTR) begin
      rd_val[15:0] = st_r.sp;
    end else if (paddr == imr_pkg::A_STKOVB) begin
      rd_val[15:0] = st_r.ovb;
    end else if (paddr == imr_pkg::A_STKUNB) begin
      rd_val[15:0] = st_r.unb;
    end else if (paddr == imr_pkg::A_CSEG) begin
      rd_val[1:0] = st_r.code_segment_pointer;
    end else if (paddr >= imr_pkg::A_DPP0 && paddr <= imr_pkg::A_DPP3 && paddr[1:0] == 2'h0) begin
      rd_val[9:0] = st_r.data_page_pointer[di];
    end else if (paddr == imr_pkg::A_STATUS) begin
      rd_val[imr_pkg::ST_OVF_BIT]  = ovf;
      rd_val[imr_pkg::ST_UNF_BIT]  = unf;
      rd_val[imr_pkg::ST_AREA_BIT] = out_area;
      rd_val[imr_pkg::ST_ERR_BIT]  = st_r.acc_err;
    end else begin
      mapped = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    ram_we   = 1'b0;
    ram_act  = 1'b0;
    ram_mask = 16'hFFFF;
    ram_wd   = req_i.wdata;
    a16      = 16'h0000;
    gpr_a    = 16'h0000;
    gpr_n    = 4'h0;
    page     = st_r.data_page_pointer[req_i.dsel];

    // APB access: one wait state, write lands on the ready edge
    st_nxt.pready = psel && penable && !st_r.pready;
    if (psel && penable && !st_r.pready) begin
      st_nxt.prdata  = rd_val;
      st_nxt.pslverr = !mapped;
    end
    if (psel && penable && st_r.pready && pwrite && mapped) begin
      if (paddr == imr_pkg::A_SYSCFG) begin
        st_nxt.seg_dis  = pwdata[imr_pkg::CFG_SEGDIS_BIT];
        st_nxt.stk_size = pwdata[imr_pkg::CFG_STACK_SIZE_FIELD_LSB +: 2];
      end else if (paddr == imr_pkg::A_CTXPTR) begin
        if (cp_ok(pwdata[15:0])) begin
          st_nxt.cp = pwdata[15:0];
        end
      end else if (paddr == imr_pkg::A_STKPTR) begin
        st_nxt.sp = {pwdata[15:1], 1'b0};
      end else if (paddr == imr_pkg::A_STKOVB) begin
        st_nxt.ovb = {pwdata[15:1], 1'b0};
      end else if (paddr == imr_pkg::A_STKUNB) begin
        st_nxt.unb = {pwdata[15:1], 1'b0};
      end else if (paddr == imr_pkg::A_CSEG) begin
        st_nxt.code_segment_pointer = pwdata[1:0];
      end else if (paddr == imr_pkg::A_STATUS) begin
        if (pwdata[imr_pkg::ST_ERR_BIT]) begin
          st_nxt.acc_err = 1'b0;
        end
      end else begin
        st_nxt.data_page_pointer[di] = pwdata[9:0];
      end
    end

    // CPU request, answered on the next edge; CPU updates win over APB
    st_nxt.rsp.valid     = req_i.valid;
    st_nxt.rsp.kind      = req_i.kind;
    st_nxt.rsp.err_bit   = 1'b0;
    st_nxt.rsp.err_stack = 1'b0;
    st_nxt.rsp.err_cp    = 1'b0;
    st_nxt.rsp.phys      = 18'h00000;
    if (req_i.valid) begin
      case (req_i.kind)
        imr_pkg::K_FETCH: begin
          st_nxt.rsp.phys = {st_r.seg_dis ? 2'h0 : st_r.code_segment_pointer, req_i.addr[15:1], 1'b0};
        end
        imr_pkg::K_JUMP_SEG: begin
          st_nxt.code_segment_pointer      = req_i.field[1:0];
          st_nxt.rsp.phys = {st_r.seg_dis ? 2'h0 : req_i.field[1:0],
                             req_i.addr[15:1], 1'b0};
        end
        imr_pkg::K_LONG: begin
          st_nxt.rsp.phys = {page[3:0], req_i.addr[13:0]};
          if (st_r.seg_dis) begin
            st_nxt.rsp.phys[17:16] = 2'h0;
          end
        end
        imr_pkg::K_SHORT: begin
          if (req_i.fsel == imr_pkg::F_2BIT) begin
            gpr_n = {2'h0, req_i.field[1:0]};
          end else begin
            gpr_n = req_i.field[3:0];
          end
          if (req_i.byte_acc) begin
            gpr_a = 16'(st_r.cp + {12'h000, gpr_n});
          end else begin
            gpr_a = 16'(st_r.cp + {11'h000, gpr_n, 1'b0});
          end
          if (req_i.fsel == imr_pkg::F_8BIT && req_i.field[7:4] != imr_pkg::GPR_PREFIX) begin
            gpr_a = 16'(imr_pkg::SFR_BASE + {7'h00, req_i.field, 1'b0});
          end
          st_nxt.rsp.phys = {2'h0, gpr_a};
        end
        imr_pkg::K_BIT: begin
          a16 = {req_i.addr[15:1], 1'b0};
          st_nxt.rsp.phys = {2'h0, a16};
          if (!((a16 >= imr_pkg::BITRAM_LO && a16 <= imr_pkg::RAM_LAST) ||
                (a16 >= imr_pkg::BITSFR_LO && a16 <= imr_pkg::BITSFR_HI) ||
                in_bank(a16, st_r.cp))) begin
            st_nxt.rsp.err_bit = 1'b1;
          end
        end
        imr_pkg::K_PUSH, imr_pkg::K_SWITCH_CONTEXT_INSTR: begin
          if (req_i.byte_acc) begin
            st_nxt.rsp.err_stack = 1'b1;
          end else if (req_i.kind == imr_pkg::K_SWITCH_CONTEXT_INSTR && !cp_ok(req_i.wdata)) begin
            st_nxt.rsp.err_cp = 1'b1;
          end else begin
            st_nxt.sp       = 16'(st_r.sp - 16'h0002);
            st_nxt.rsp.phys = {2'h0, st_nxt.sp};
            if (req_i.kind == imr_pkg::K_SWITCH_CONTEXT_INSTR) begin
              ram_wd    = st_r.cp;
              st_nxt.cp = req_i.wdata;
            end
          end
        end
        imr_pkg::K_POP: begin
          if (req_i.byte_acc) begin
            st_nxt.rsp.err_stack = 1'b1;
          end else begin
            st_nxt.rsp.phys = {2'h0, st_r.sp};
            st_nxt.sp       = 16'(st_r.sp + 16'h0002);
          end
        end
        imr_pkg::K_PEC_PTR: begin
          st_nxt.rsp.phys = {2'h0, 16'(imr_pkg::PEC_BASE +
                            {11'h000, req_i.field[2:0], req_i.dsel[0], 1'b0})};
        end
        imr_pkg::K_PEC_XFER: begin
          st_nxt.rsp.phys = {2'h0, req_i.addr};
        end
        imr_pkg::K_VECTOR: begin
          st_nxt.rsp.phys = {2'h0, 6'h00, req_i.field, 2'h0};
        end
        default: begin
          st_nxt.rsp.phys = 18'h00000;
        end
      endcase
    end
    st_nxt.rsp.region = req_i.valid ? region_of(st_nxt.rsp.phys) : imr_pkg::R_NONE;
    if (req_i.kind == imr_pkg::K_BIT && st_nxt.rsp.region == imr_pkg::R_EXT) begin
      st_nxt.rsp.err_bit = req_i.valid;
    end

    // Internal RAM port, never disabled
    ram_act = req_i.valid && st_nxt.rsp.region == imr_pkg::R_RAM &&
              !st_nxt.rsp.err_bit && !st_nxt.rsp.err_stack && !st_nxt.rsp.err_cp;
    ram_idx = 9'((st_nxt.rsp.phys[15:0] - imr_pkg::RAM_BASE) >> 1);
    ram_we  = ram_act && (req_i.we || req_i.kind == imr_pkg::K_PUSH ||
              req_i.kind == imr_pkg::K_SWITCH_CONTEXT_INSTR) && req_i.kind != imr_pkg::K_POP &&
              req_i.kind != imr_pkg::K_FETCH;
    if (req_i.kind == imr_pkg::K_BIT) begin
      ram_mask = 16'(16'h0001 << req_i.field[3:0]);
      ram_wd   = {16{req_i.wdata[0]}};
    end else if (req_i.byte_acc && (req_i.kind == imr_pkg::K_LONG ||
                 req_i.kind == imr_pkg::K_SHORT || req_i.kind == imr_pkg::K_PEC_XFER)) begin
      ram_mask = st_nxt.rsp.phys[0] ? 16'hFF00 : 16'h00FF;
      ram_wd   = {2{req_i.wdata[7:0]}};
    end

    // Sticky access error; a new error wins over a clear
    if (st_nxt.rsp.err_bit || st_nxt.rsp.err_stack || st_nxt.rsp.err_cp) begin
      st_nxt.acc_err = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.stk_size <= imr_pkg::STACK_SIZE_FIELD_RST;
      st_r.cp       <= imr_pkg::CP_RST;
      st_r.sp       <= imr_pkg::SP_RST;
      st_r.ovb      <= imr_pkg::OVB_RST;
      st_r.unb      <= imr_pkg::UNB_RST;
      st_r.rsp.region <= imr_pkg::R_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge pclk) begin
    if (ram_we) begin
      mem[ram_idx] <= (mem[ram_idx] & ~ram_mask) | (ram_wd & ram_mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_r <= 16'h0000;
    end else if (ram_act) begin
      rd_r <= mem[ram_idx];
    end
  end

  assign prdata  = st_r.prdata;
  assign pready  = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign rsp_o   = st_r.rsp;
  assign rdata_o = rd_r;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fetch_even: assert property (
    rsp_o.valid && rsp_o.kind == imr_pkg::K_FETCH |-> !rsp_o.phys[0])
    else $error("fetch at odd address");
  a_segdis_seg0: assert property (
    req_i.valid && st_r.seg_dis && req_i.kind == imr_pkg::K_LONG |=> rsp_o.phys[17:16] == 2'h0)
    else $error("external access left segment 0");
  a_push_down: assert property (
    req_i.valid && req_i.kind == imr_pkg::K_PUSH && !req_i.byte_acc
    |=> st_r.sp == 16'($past(st_r.sp) - 16'h0002) && rsp_o.phys[15:0] == st_r.sp)
    else $error("push did not move stack down by one word");
  a_stack_word: assert property (
    req_i.valid && req_i.kind == imr_pkg::K_POP && req_i.byte_acc
    |=> rsp_o.err_stack && $stable(st_r.sp))
    else $error("byte stack access accepted");
  a_cp_range: assert property (
    st_r.cp >= imr_pkg::RAM_BASE && st_r.cp <= imr_pkg::CP_MAX)
    else $error("context pointer outside bank range");
  a_short_internal: assert property (
    req_i.valid && req_i.kind == imr_pkg::K_SHORT |=> rsp_o.region != imr_pkg::R_EXT)
    else $error("short mode reached external memory");
  a_bit_ext_err: assert property (
    rsp_o.valid && rsp_o.kind == imr_pkg::K_BIT && rsp_o.region == imr_pkg::R_EXT
    |-> rsp_o.err_bit && st_r.acc_err)
    else $error("external bit access not refused");
  a_pec_seg0: assert property (
    req_i.valid && req_i.kind == imr_pkg::K_PEC_XFER
    |=> rsp_o.phys == {2'h0, $past(req_i.addr)})
    else $error("transfer pointer address altered");
  a_vector_fixed: assert property (
    req_i.valid && req_i.kind == imr_pkg::K_VECTOR
    |=> rsp_o.phys[17:16] == 2'h0 && rsp_o.phys[1:0] == 2'h0 && $stable(st_r.code_segment_pointer))
    else $error("vector not in fixed segment 0 table");
  a_switch_context_instr_switch: assert property (
    req_i.valid && req_i.kind == imr_pkg::K_SWITCH_CONTEXT_INSTR && !req_i.byte_acc && cp_ok(req_i.wdata)
    |=> st_r.cp == $past(req_i.wdata) && st_r.sp == 16'($past(st_r.sp) - 16'h0002))
    else $error("context switch failed");

  c_push_pop: cover property (
    req_i.valid && req_i.kind == imr_pkg::K_PUSH ##1 req_i.valid && req_i.kind == imr_pkg::K_POP);
  c_switch_context_instr: cover property (req_i.valid && req_i.kind == imr_pkg::K_SWITCH_CONTEXT_INSTR);
  c_bit_bank: cover property (rsp_o.valid && rsp_o.kind == imr_pkg::K_BIT && !rsp_o.err_bit);
  c_ovf: cover property (ovf);

endmodule
`default_nettype wire

// File: core/imr_pkg.sv
// Constants, types and register map of the internal RAM, stack and working-register mapper
`default_nettype none
package imr_pkg;

  // ----------------------------------------------------------------------
  // APB register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] A_SYSCFG = 8'h00;
  localparam logic [7:0] A_CTXPTR = 8'h04;
  localparam logic [7:0] A_STKPTR = 8'h08;
  localparam logic [7:0] A_STKOVB = 8'h0C;
  localparam logic [7:0] A_STKUNB = 8'h10;
  localparam logic [7:0] A_CSEG   = 8'h14;
  localparam logic [7:0] A_DPP0   = 8'h18;
  localparam logic [7:0] A_DPP3   = 8'h24;
  localparam logic [3:0] DPP0_IDX = 4'h6;
  localparam logic [7:0] A_STATUS = 8'h28;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CFG_SEGDIS_BIT = 0;
  localparam int CFG_STACK_SIZE_FIELD_LSB  = 1;
  localparam int ST_OVF_BIT     = 0;
  localparam int ST_UNF_BIT     = 1;
  localparam int ST_AREA_BIT    = 2;
  localparam int ST_ERR_BIT     = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] CP_RST   = 16'hFC00;
  localparam logic [15:0] SP_RST   = 16'hFC00;
  localparam logic [15:0] OVB_RST  = 16'hFA00;
  localparam logic [15:0] UNB_RST  = 16'hFC00;
  localparam logic [1:0]  STACK_SIZE_FIELD_RST = 2'h0;

  // ----------------------------------------------------------------------
  // Memory map
  // ----------------------------------------------------------------------
  localparam logic [15:0] RAM_BASE     = 16'hFA00;
  localparam logic [15:0] RAM_LAST     = 16'hFDFF;
  localparam logic [15:0] STK_TOP_EXCL = 16'hFC00;
  localparam logic [15:0] STK_BYTES    = 16'h0200;
  localparam logic [15:0] BITRAM_LO    = 16'hFD00;
  localparam logic [15:0] PEC_BASE     = 16'hFDE0;
  localparam logic [15:0] CP_MAX       = 16'hFDE0;
  localparam logic [15:0] BANK_BYTES   = 16'h0020;
  localparam logic [15:0] SFR_BASE     = 16'hFE00;
  localparam logic [15:0] BITSFR_LO    = 16'hFF00;
  localparam logic [15:0] BITSFR_HI    = 16'hFFDF;
  localparam logic [3:0]  GPR_PREFIX   = 4'hF;

  typedef enum logic [3:0] {
    K_FETCH, K_LONG, K_SHORT, K_BIT, K_PUSH, K_POP,
    K_PEC_PTR, K_PEC_XFER, K_VECTOR, K_JUMP_SEG, K_SWITCH_CONTEXT_INSTR
  } imr_kind_t;

  typedef enum logic [1:0] {R_EXT, R_RAM, R_SFR, R_NONE} imr_region_t;
  typedef enum logic [1:0] {F_2BIT, F_4BIT, F_8BIT} imr_fsel_t;

  typedef struct packed {
    logic        valid;
    imr_kind_t   kind;
    logic        we;
    logic        byte_acc;
    imr_fsel_t   fsel;
    logic [1:0]  dsel;
    logic [7:0]  field;
    logic [15:0] addr;
    logic [15:0] wdata;
  } imr_req_t;

  typedef struct packed {
    logic        valid;
    imr_kind_t   kind;
    imr_region_t region;
    logic [17:0] phys;
    logic        err_bit;
    logic        err_stack;
    logic        err_cp;
  } imr_rsp_t;

endpackage
`default_nettype wire

// File: dv/imr_cpu_model.sv
// CPU core model that issues single mapper requests
`default_nettype none
module imr_cpu_model (
  input  wire logic              pclk,     // Clock
  input  wire logic              presetn,  // Async reset, active low
  input  wire logic              fire,     // Issue cmd at next edge
  input  wire imr_pkg::imr_req_t cmd,      // Request to issue
  output imr_pkg::imr_req_t      req_o     // Request bus to mapper
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------------
  // One request per fire, no sequential fetch across region ends
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_o <= '0;
    end else if (fire) begin
      req_o <= cmd;
    end else begin
      // Idle fields toggle so stale values are never reused
      req_o <= {1'b0, ~req_o[$bits(imr_pkg::imr_req_t)-2:0]};
    end
  end
endmodule
`default_nettype wire

// File: dv/internal_ram_stack_gpr_map_tb.sv
// Self-checking bench of the memory mapper
`default_nettype none
module internal_ram_stack_gpr_map_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [7:0]        paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd, seed = 32'h34446680;
  logic              pready, pslverr, er;
  logic [15:0]       rdata_o, cp, w;
  imr_pkg::imr_req_t cmd = '0, req_i, r;
  imr_pkg::imr_rsp_t rsp_o;
  int                fail_count = 0, compares = 0;
  always #25 pclk = ~pclk;
  imr_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .fire(fire), .cmd(cmd), .req_o(req_i));
  imr_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_i(req_i), .rsp_o(rsp_o), .rdata_o(rdata_o));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] stk_lo(int s);
    return 16'(16'hFC00 - (16'h0200 >> s));
  endfunction
  // Word register n at base plus 2n; byte register n in word n/2, half n[0]
  function automatic logic [17:0] reg_addr(logic [15:0] c, logic [3:0] n, logic b);
    return {2'h0, 16'(c + (b ? 2 * n[3:1] + n[0] : 2 * n))};
  endfunction
  function automatic imr_pkg::imr_req_t mk(imr_pkg::imr_kind_t k, logic [15:0] a,
    logic [7:0] f, logic b, logic [15:0] wd);
    mk = '0;
    mk.valid = 1'b1;
    mk.kind = k;
    mk.addr = a;
    mk.field = f;
    mk.byte_acc = b;
    mk.fsel = imr_pkg::F_4BIT;
    mk.wdata = wd;
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cpu(imr_pkg::imr_req_t r);
    @(posedge pclk);
    cmd <= r;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    @(posedge pclk);
    #1;
  endtask
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  logic [31:0] rv [5] = '{32'h0, 32'hFC00, 32'hFC00, 32'hFA00, 32'hFC00};
  logic [15:0] ba [4] = '{16'hFA00, 16'hFD10, 16'hFA24, 16'h3000};
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      apb(0, ra[i], 0);
      chk("reset value", rd, rv[i]);
    end
    apb(1, 8'h2C, 0);
    chk("unmapped", er, 1);
    w = 16'(xs());
    cpu(mk(imr_pkg::K_PUSH, 0, 0, 0, w));
    chk("push phys", rsp_o.phys, 18'h0FBFE);
    cpu(mk(imr_pkg::K_POP, 0, 0, 0, 0));
    chk("pop data", rdata_o, w);
    cpu(mk(imr_pkg::K_PUSH, 0, 0, 1, w));
    chk("byte push", rsp_o.err_stack, 1);
    cpu(mk(imr_pkg::K_SWITCH_CONTEXT_INSTR, 0, 0, 0, 16'hFA20));
    apb(0, imr_pkg::A_CTXPTR, 0);
    chk("new context", rd, 32'hFA20);
    cpu(mk(imr_pkg::K_POP, 0, 0, 0, 0));
    chk("saved context", rdata_o, 16'hFC00);
    cpu(mk(imr_pkg::K_SWITCH_CONTEXT_INSTR, 0, 0, 0, 16'hFDF0));
    chk("bad context", rsp_o.err_cp, 1);
    apb(0, imr_pkg::A_STATUS, 0);
    chk("error flag", rd[imr_pkg::ST_ERR_BIT], 1);
    apb(1, imr_pkg::A_STATUS, 32'h0000_0008);
    apb(0, imr_pkg::A_STATUS, 0);
    chk("error clear", rd[imr_pkg::ST_ERR_BIT], 0);
    cp = 16'hFA20;
    for (int n = 0; n < 16; n++) begin
      cpu(mk(imr_pkg::K_SHORT, 0, n, 0, 0));
      chk("word reg", rsp_o.phys, cp + 2 * n);
      cpu(mk(imr_pkg::K_SHORT, 0, n, 1, 0));
      chk("byte reg", rsp_o.phys, cp + n);
    end
    r = mk(imr_pkg::K_SHORT, 0, 8'h12, 0, 0);
    r.fsel = imr_pkg::F_8BIT;
    cpu(r);
    chk("short ctrl reg", rsp_o.phys, 18'h0FE24);
    r.field = 8'hF3;
    cpu(r);
    chk("short 8bit reg", rsp_o.phys, cp + 6);
    r.fsel = imr_pkg::F_2BIT;
    r.field = 8'hFE;
    cpu(r);
    chk("short 2bit reg", rsp_o.phys, cp + 4);
    for (int k = 0; k < 24; k++) begin
      w = 16'(xs());
      cpu(mk(imr_pkg::K_SHORT, 0, {4'h0, w[3:0]}, w[4], 0));
      chk("random reg", rsp_o.phys, reg_addr(cp, w[3:0], w[4]));
      cpu(mk(imr_pkg::K_PUSH, 0, 0, 0, w));
      cpu(mk(imr_pkg::K_POP, 0, 0, 0, 0));
      chk("random stack", rdata_o, w);
    end
    foreach (ba[i]) begin
      cpu(mk(imr_pkg::K_BIT, ba[i], 0, 0, 0));
      chk("bit access", rsp_o.err_bit, i == 0 || i == 3);
    end
    w = 16'(16'h3A00 | (xs() & 32'h0000_01FE));
    for (int d = 3; d >= 0; d -= 3) begin
      apb(1, imr_pkg::A_DPP0, d);
      cpu(mk(imr_pkg::K_LONG, w, 0, 0, 0));
      chk("long phys", rsp_o.phys, {d[3:0], w[13:0]});
      chk("long region", rsp_o.region, d == 3 ? imr_pkg::R_RAM : imr_pkg::R_EXT);
    end
    cpu(mk(imr_pkg::K_PEC_PTR, 0, 3, 0, 0));
    chk("transfer ptr", rsp_o.phys, 18'h0FDEC);
    cpu(mk(imr_pkg::K_PEC_XFER, 16'h8000, 0, 0, 0));
    chk("transfer seg0", rsp_o.phys, 18'h08000);
    cpu(mk(imr_pkg::K_VECTOR, 16'h1234, 5, 0, 0));
    chk("vector", rsp_o.phys, 18'h00014);
    apb(1, imr_pkg::A_SYSCFG, 1);
    apb(1, imr_pkg::A_CSEG, 2);
    apb(1, imr_pkg::A_DPP0, 5);
    cpu(mk(imr_pkg::K_LONG, w, 0, 0, 0));
    chk("long seg0", rsp_o.phys, {4'h1, w[13:0]});
    cpu(mk(imr_pkg::K_FETCH, 16'h1235, 0, 0, 0));
    chk("fetch", rsp_o.phys, 18'h01234);
    cpu(mk(imr_pkg::K_JUMP_SEG, 16'h0101, 1, 0, 0));
    chk("jump seg0", rsp_o.phys, 18'h00100);
    apb(1, imr_pkg::A_SYSCFG, 0);
    cpu(mk(imr_pkg::K_FETCH, 16'h1235, 0, 0, 0));
    chk("fetch seg", rsp_o.phys, 18'h11234);
    for (int s = 0; s < 4; s++) begin
      apb(1, imr_pkg::A_SYSCFG, s << 1);
      apb(1, imr_pkg::A_STKPTR, stk_lo(s) - 2);
      apb(0, imr_pkg::A_STATUS, 0);
      chk("stack out", rd[imr_pkg::ST_AREA_BIT], 1);
      chk("overflow", rd[imr_pkg::ST_OVF_BIT], s == 0);
      apb(1, imr_pkg::A_STKPTR, stk_lo(s));
      apb(0, imr_pkg::A_STATUS, 0);
      chk("stack in", rd[imr_pkg::ST_AREA_BIT], 0);
    end
    apb(1, imr_pkg::A_STKPTR, 32'h0000_FC02);
    apb(0, imr_pkg::A_STATUS, 0);
    chk("underflow", rd[imr_pkg::ST_UNF_BIT], 1);
    conclude();
  end
endmodule
`default_nettype wire
